// ==== bench/rbe_mod_model.sv ====
// Purpose: Modulator model that accepts coded symbols
// Assumes: Symbols are held until accepted
// Notes:   Slow mode accepts one cycle in eight
`timescale 1ns/1ps
module rbe_mod_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_slow,
  output logic      o_ready
);
  logic [2:0] cnt_ff;
  // ==========================================================================
  // Acceptance pattern
  always_ff @(posedge i_clk) begin
    if (i_rst) cnt_ff <= 3'h0;
    else cnt_ff <= cnt_ff + 3'h1;
  end
  assign o_ready = !i_rst && (!i_slow || (cnt_ff == 3'h7));
endmodule

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench of the bit-stream encoder
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Expected streams are built from a fixed pattern
`timescale 1ns/1ps
module testbench;
  import rbe_pkg::*;
  localparam logic [15:0] PAT = 16'hB4E1;
  logic     clk = 0, rst = 1, tx_bit = 0, tx_valid = 0, dem_sym = 0, dem_valid = 0, slow = 0;
  rbe_cfg_t cfg = '0;
  logic     tx_ready, mod_sym, mod_valid, mod_ready, rx_bit, rx_valid, rx_err;
  logic     exp_q[$], q_mod[$], q_rx[$];
  int       failures = 0, n_tests = 0, n_err = 0, n_full = 0;
  always #2.5 clk = ~clk;
  // ==========================================================================
  // Design and modulator model
  rbe_encoder dut_u (.I_SYS_CLK(clk), .I_RESET(rst), .I_CFG(cfg), .I_TX_BIT(tx_bit),
    .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .O_MOD_SYM(mod_sym), .O_MOD_VALID(mod_valid),
    .I_MOD_READY(mod_ready), .I_DEM_SYM(dem_sym), .I_DEM_VALID(dem_valid), .O_RX_BIT(rx_bit),
    .O_RX_VALID(rx_valid), .O_RX_CODE_ERR(rx_err));
  rbe_mod_model mod_u (.i_clk(clk), .i_rst(rst), .i_slow(slow), .o_ready(mod_ready));
  // ==========================================================================
  // Monitors
  always @(posedge clk) begin
    if (mod_valid === 1'h1 && mod_ready === 1'h1) q_mod.push_back(mod_sym);
    if (rx_valid === 1'h1) q_rx.push_back(rx_bit);
    if (rx_err === 1'h1) n_err++;
    if (tx_valid && tx_ready === 1'h0) n_full++;
  end
  // ==========================================================================
  // Shared tasks
  task automatic end_of_test();
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_cnt(string nm, int e, int g);
    n_tests++;
    if (g != e) begin
      failures++;
      $display("[FAIL] %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset(logic [2:0] c);
    rst = 1;
    cfg = c;
    repeat (5) tick();
    rst = 0;
    tick();
    q_mod.delete();
    q_rx.delete();
    n_err = 0;
    n_full = 0;
  endtask
  task automatic build(logic [2:0] c);
    logic lvl, b;
    lvl = 1'h0;
    exp_q.delete();
    for (int i = 15; i >= 0; i--) begin
      b = PAT[i] ^ c[2];
      if (c[1]) begin
        lvl = lvl ^ b;
        b = lvl;
      end
      exp_q.push_back(b);
      if (c[0]) exp_q.push_back(~b);
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic tx_scn(logic [2:0] c, logic s);
    int k;
    do_reset(c);
    slow = s;
    build(c);
    for (int i = 15; i >= 0; i--) begin
      tx_valid = 1;
      tx_bit = PAT[i];
      for (k = 0; k < 40 && tx_ready !== 1'h1; k++) tick();
      if (k == 40) begin
        failures++;
        end_of_test();
      end
      tick();
    end
    tx_valid = 0;
    for (k = 0; k < 400 && q_mod.size() < exp_q.size(); k++) tick();
    if (k == 400) begin
      failures++;
      end_of_test();
    end
    repeat (20) tick();
    chk_cnt("mod count", exp_q.size(), q_mod.size());
    foreach (exp_q[i]) chk_bit("mod sym", exp_q[i], q_mod[i]);
    if (s) chk_cnt("fifo full seen", 1, n_full > 0);
  endtask
  task automatic rx_scn(logic [2:0] c, logic inv);
    do_reset(c);
    build(c);
    foreach (exp_q[i]) begin
      dem_valid = 1;
      dem_sym = exp_q[i] ^ inv;
      tick();
      if (i % 3 == 1) begin
        dem_valid = 0;
        dem_sym = ~dem_sym;
        tick();
      end
    end
    dem_valid = 0;
    repeat (3) tick();
    chk_cnt("rx count", 16, q_rx.size());
    chk_cnt("no code err", 0, n_err);
    for (int i = inv; i < 16; i++) chk_bit("rx bit", PAT[15-i], q_rx[i]);
  endtask
  task automatic rx_err_scn();
    do_reset(3'h1);
    dem_valid = 1;
    dem_sym = 1;
    tick();
    tick();
    dem_sym = 0;
    tick();
    dem_valid = 0;
    dem_sym = 1;
    repeat (3) tick();
    chk_cnt("code err", 1, n_err);
    chk_cnt("rx count", 1, q_rx.size());
    chk_bit("rx bit", 1'h1, q_rx[0]);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    for (int c = 0; c < 8; c++) begin
      tx_scn(c[2:0], c[0]);
      rx_scn(c[2:0], 1'h0);
    end
    rx_scn(3'h2, 1'h1);
    rx_scn(3'h3, 1'h1);
    rx_err_scn();
    end_of_test();
  end
endmodule

// ==== common/rbe_pkg.sv ====
// Purpose: Shared constants and types of the radio bit-stream encoder
// Assumes: One clock, synchronous active-high reset
// Notes:   Configuration travels as one packed struct
package rbe_pkg;

  // ==========================================================================
  // Sizes and reset values
  localparam int   FIFO_DEPTH = 4;
  localparam int   FIFO_WIDTH = 1;
  localparam logic LVL_RST    = 1'b0;
  localparam logic PREV_RST   = 1'b0;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic invert;
    logic diff;
    logic manch;
  } rbe_cfg_t;

endpackage

// ==== core/rbe_encoder.sv ====
// Purpose: Bit-stream encoder between framing unit and modulator/demodulator
// Assumes: Inputs synchronous to I_SYS_CLK; demodulator stream never stalls
// Notes:   Transmit bits pass a small FIFO; receive path is unbuffered
//
// Notes on behaviour
// - Carries bits framer to modulator and demodulator to framer.
// - Inversion option complements every bit; otherwise bits pass unchanged.
// - Transmit differential: zero keeps the level, one toggles it.
// - Receive differential: one when levels differ, zero when equal.
// - Manchester: each bit becomes two opposite halves, doubling symbol rate.
`timescale 1ns/1ps

// ============================================================================
// Small FIFO with valid/ready on both sides
module rbe_fifo
  import rbe_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("rbe_fifo: DEPTH must be >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             rdy_ff;
  logic [AW-1:0]    nxt_wr;
  logic [AW-1:0]    nxt_rd;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && rdy_ff;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data  = mem_ff[rd_ff];
  assign o_in_ready  = rdy_ff;

  always_comb begin
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt < (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end
endmodule

// ============================================================================
// Encoder top
module rbe_encoder
  import rbe_pkg::*;
(
  input  wire logic     I_SYS_CLK,
  input  wire logic     I_RESET,
  input  wire rbe_cfg_t I_CFG,
  input  wire logic     I_TX_BIT,
  input  wire logic     I_TX_VALID,
  output logic          O_TX_READY,
  output logic          O_MOD_SYM,
  output logic          O_MOD_VALID,
  input  wire logic     I_MOD_READY,
  input  wire logic     I_DEM_SYM,
  input  wire logic     I_DEM_VALID,
  output logic          O_RX_BIT,
  output logic          O_RX_VALID,
  output logic          O_RX_CODE_ERR
);

  // ==========================================================================
  // Transmit buffer
  logic fifo_data;
  logic fifo_vld;
  logic load;

  rbe_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_SYS_CLK),
    .i_rst       (I_RESET),
    .i_in_data   (I_TX_BIT),
    .i_in_valid  (I_TX_VALID),
    .o_in_ready  (O_TX_READY),
    .o_out_data  (fifo_data),
    .o_out_valid (fifo_vld),
    .i_out_ready (load)
  );

  // ==========================================================================
  // Transmit coding
  logic sym_ff;
  logic vld_ff;
  logic half_ff;
  logic lvl_ff;
  logic nxt_sym;
  logic nxt_vld;
  logic nxt_half;
  logic nxt_lvl;
  logic tx_b;
  logic out_free;

  assign out_free = !vld_ff || I_MOD_READY;
  assign load     = fifo_vld && !half_ff && out_free;
  assign tx_b     = fifo_data ^ I_CFG.invert;

  always_comb begin
    nxt_sym  = sym_ff;
    nxt_vld  = vld_ff;
    nxt_half = half_ff;
    nxt_lvl  = lvl_ff;
    if (load) begin
      if (I_CFG.diff) begin
        nxt_lvl = lvl_ff ^ tx_b;
        nxt_sym = lvl_ff ^ tx_b;
      end else begin
        nxt_sym = tx_b;
      end
      nxt_half = I_CFG.manch;
      nxt_vld  = 1'b1;
    end else if (half_ff && out_free) begin
      nxt_sym  = !sym_ff;
      nxt_half = 1'b0;
      nxt_vld  = 1'b1;
    end else if (vld_ff && I_MOD_READY) begin
      nxt_vld = 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      sym_ff  <= 1'b0;
      vld_ff  <= 1'b0;
      half_ff <= 1'b0;
      lvl_ff  <= LVL_RST;
    end else begin
      sym_ff  <= nxt_sym;
      vld_ff  <= nxt_vld;
      half_ff <= nxt_half;
      lvl_ff  <= nxt_lvl;
    end
  end

  assign O_MOD_SYM   = sym_ff;
  assign O_MOD_VALID = vld_ff;

  // ==========================================================================
  // Receive decoding: Manchester, then differential, then inversion
  logic ph_ff;
  logic first_ff;
  logic prev_ff;
  logic rbit_ff;
  logic rvld_ff;
  logic rerr_ff;
  logic nxt_ph;
  logic nxt_first;
  logic nxt_prev;
  logic nxt_rbit;
  logic nxt_rvld;
  logic nxt_rerr;
  logic got;
  logic d;

  always_comb begin
    nxt_ph    = ph_ff;
    nxt_first = first_ff;
    nxt_prev  = prev_ff;
    nxt_rbit  = rbit_ff;
    nxt_rvld  = 1'b0;
    nxt_rerr  = 1'b0;
    got       = 1'b0;
    d         = I_DEM_SYM;
    if (I_DEM_VALID) begin
      if (I_CFG.manch) begin
        if (!ph_ff) begin
          nxt_first = I_DEM_SYM;
          nxt_ph    = 1'b1;
        end else if (I_DEM_SYM == first_ff) begin
          nxt_rerr  = 1'b1;
          nxt_first = I_DEM_SYM;
        end else begin
          d      = first_ff;
          got    = 1'b1;
          nxt_ph = 1'b0;
        end
      end else begin
        got = 1'b1;
      end
    end
    if (got) begin
      if (I_CFG.diff) begin
        nxt_rbit = (d ^ prev_ff) ^ I_CFG.invert;
        nxt_prev = d;
      end else begin
        nxt_rbit = d ^ I_CFG.invert;
      end
      nxt_rvld = 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      ph_ff    <= 1'b0;
      first_ff <= 1'b0;
      prev_ff  <= PREV_RST;
      rbit_ff  <= 1'b0;
      rvld_ff  <= 1'b0;
      rerr_ff  <= 1'b0;
    end else begin
      ph_ff    <= nxt_ph;
      first_ff <= nxt_first;
      prev_ff  <= nxt_prev;
      rbit_ff  <= nxt_rbit;
      rvld_ff  <= nxt_rvld;
      rerr_ff  <= nxt_rerr;
    end
  end

  assign O_RX_BIT      = rbit_ff;
  assign O_RX_VALID    = rvld_ff;
  assign O_RX_CODE_ERR = rerr_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);

  chk_tx_hold_stall: assert property (
    O_MOD_VALID && !I_MOD_READY |=> O_MOD_VALID && $stable(O_MOD_SYM))
    else $error("Modulator symbol changed while stalled");
  chk_rx_plain_flow: assert property (
    I_DEM_VALID && !I_CFG.manch |=> O_RX_VALID)
    else $error("Received bit not delivered");
  chk_tx_invert_plain: assert property (
    load && !I_CFG.diff && !I_CFG.manch |=> O_MOD_SYM == ($past(fifo_data) ^ $past(I_CFG.invert)))
    else $error("Plain transmit bit wrong");
  chk_tx_diff_level: assert property (
    load && I_CFG.diff && !I_CFG.manch |=> O_MOD_SYM == ($past(lvl_ff) ^ $past(tx_b)) && lvl_ff == O_MOD_SYM)
    else $error("Differential level wrong");
  chk_rx_diff_decode: assert property (
    I_DEM_VALID && I_CFG.diff && !I_CFG.manch && !I_CFG.invert
    |=> O_RX_VALID && O_RX_BIT == ($past(I_DEM_SYM) ^ $past(prev_ff)))
    else $error("Differential decode wrong");
  chk_manch_second_half: assert property (
    O_MOD_VALID && I_MOD_READY && half_ff |=> O_MOD_VALID && O_MOD_SYM == !$past(O_MOD_SYM))
    else $error("Manchester second half not complemented");
  chk_manch_first_polarity: assert property (
    load && I_CFG.manch && !I_CFG.diff |=> half_ff && O_MOD_SYM == $past(tx_b))
    else $error("Manchester first half polarity wrong");
  chk_rx_manch_pair: assert property (
    I_DEM_VALID && I_CFG.manch && ph_ff && I_DEM_SYM != first_ff |=> O_RX_VALID && !O_RX_CODE_ERR)
    else $error("Valid Manchester pair not decoded");

  cov_tx_manch: cover property (load && I_CFG.manch ##1 half_ff ##[1:4] !half_ff);
  cov_rx_err: cover property (O_RX_CODE_ERR);
  cov_fifo_full: cover property (O_TX_READY ##1 !O_TX_READY ##[1:16] O_TX_READY);
endmodule
